// ===== design/cicid_ctrl.sv
// Purpose: cpu interface control register and identification registers
// Assumes: one-cycle strobes, read data the cycle after the read strobe
// Notes:   security extensions and lockdown are strap parameters
`include "cicid_map.svh"
module cicid_ctrl
  import cicid_pkg::*;
#(
  parameter bit SEC_EXT  = 1'b1,
  parameter bit LOCKDOWN = 1'b1
)
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  input  wire logic        accSecure,
  input  wire logic        lockdownPin,
  input  wire logic        secIrqPend,
  input  wire logic        nsIrqPend,
  output logic [31:0]      regRdData,
  output logic             secIrqOut,
  output logic             nsIrqOut
);
  // ============================================================
  // declarations
  logic       enNs_reg;
  logic       enNs_next;
  logic       enS_reg;
  logic       enS_next;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;
  cicid_sel_t sel_reg;
  cicid_sel_t sel_next;
  logic       secIrq_reg;
  logic       secIrq_next;
  logic       nsIrq_reg;
  logic       nsIrq_next;
  logic       lockLevel;
  logic       isCtrl;
  logic       isId;
  logic [2:0] idSel;
  logic [7:0] idByte;
  logic       secView;
  logic       secLocked;

  // ============================================================
  // lockdown pin crosses in through two stages
  cicid_sync2 u_lock_sync (
    .mclk     (mclk),
    .sysRst   (sys_rst),
    .clkEn    (clkEn),
    .pinIn    (lockdownPin),
    .levelOut (lockLevel)
  );

  // ============================================================
  // address decode
  always_comb
  begin
    isCtrl = (regAddr == `CICID_OFF_CTRL);
    isId   = 1'b1;
    idSel  = 3'h0;
    case (regAddr)
      `CICID_OFF_PID0: idSel = 3'h0;
      `CICID_OFF_PID1: idSel = 3'h1;
      `CICID_OFF_PID2: idSel = 3'h2;
      `CICID_OFF_PID3: idSel = 3'h3;
      `CICID_OFF_PID4: idSel = 3'h4;
      `CICID_OFF_PID5: idSel = 3'h5;
      `CICID_OFF_PID6: idSel = 3'h6;
      `CICID_OFF_PID7: idSel = 3'h7;
      default:         isId  = 1'b0;
    endcase
  end

  // without security every access sees the single non-secure layout
  assign secView   = SEC_EXT && accSecure;
  assign secLocked = LOCKDOWN && SEC_EXT && lockLevel;

  cicid_id_rom u_id_rom (
    .mclk    (mclk),
    .sysRst  (sys_rst),
    .clkEn   (clkEn),
    .rdEn    (regRdStb && isId),
    .byteSel (idSel),
    .rdByte  (idByte)
  );

  // ============================================================
  // control register copies
  always_comb
  begin
    enNs_next = enNs_reg;
    enS_next  = enS_reg;
    if (clkEn && regWrStb && isCtrl)
    begin
      if (!secView)
        enNs_next = regWrData[`CICID_CTRL_EN_BIT];
      else if (!secLocked)
      begin
        enS_next  = regWrData[`CICID_CTRL_EN_BIT];
        enNs_next = regWrData[`CICID_CTRL_ENNS_BIT];
      end
    end
    // id writes fall through untouched
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      enNs_reg <= `CICID_CTRL_RESET;
      enS_reg  <= `CICID_CTRL_RESET;
    end
    else
    begin
      enNs_reg <= enNs_next;
      enS_reg  <= enS_next;
    end
  end

  // ============================================================
  // read path; id byte arrives registered, so merge one cycle later
  always_comb
  begin
    sel_next    = sel_reg;
    rdData_next = rdData_reg;
    if (clkEn)
    begin
      sel_next    = CICID_SEL_NONE;
      rdData_next = 32'h0000_0000;
      if (regRdStb && isCtrl)
      begin
        sel_next = CICID_SEL_CTRL;
        if (secView)
          rdData_next = {30'h0, enNs_reg, enS_reg};
        else
          rdData_next = {31'h0, enNs_reg};
      end
      else if (regRdStb && isId)
        sel_next = CICID_SEL_ID;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sel_reg    <= CICID_SEL_NONE;
      rdData_reg <= 32'h0000_0000;
    end
    else
    begin
      sel_reg    <= sel_next;
      rdData_reg <= rdData_next;
    end
  end

  always_comb
  begin
    case (sel_reg)
      CICID_SEL_ID:   regRdData = {24'h0, idByte};
      CICID_SEL_CTRL: regRdData = rdData_reg;
      CICID_SEL_NONE: regRdData = 32'h0000_0000;
      default:        regRdData = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // interrupt gating
  always_comb
  begin
    secIrq_next = secIrq_reg;
    nsIrq_next  = nsIrq_reg;
    if (clkEn)
    begin
      // secure side ignores the non-secure enable when SEC_EXT is set; without it, it follows that enable
      secIrq_next = secIrqPend && (SEC_EXT ? enS_reg : enNs_reg);
      nsIrq_next  = nsIrqPend && enNs_reg;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      secIrq_reg <= 1'b0;
      nsIrq_reg  <= 1'b0;
    end
    else
    begin
      secIrq_reg <= secIrq_next;
      nsIrq_reg  <= nsIrq_next;
    end
  end

  assign secIrqOut = secIrq_reg;
  assign nsIrqOut  = nsIrq_reg;

  // ============================================================
  // checks
  property p_ns_gate;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && !enNs_reg) |=> !nsIrqOut;
  endproperty
  a_ns_gate: assert property (p_ns_gate)
    else $error("non-secure irq while disabled");

  property p_sec_indep;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && SEC_EXT && enS_reg && secIrqPend) |=> secIrqOut;
  endproperty
  a_sec_indep: assert property (p_sec_indep)
    else $error("secure irq blocked");

  property p_lock;
    @(posedge mclk) disable iff (sys_rst)
      secLocked && regWrStb && secView |=> $stable(enS_reg);
  endproperty
  a_lock: assert property (p_lock)
    else $error("secure copy changed under lockdown");

  property p_ns_write;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && regWrStb && isCtrl && !secView)
      |=> enNs_reg == $past(regWrData[0]) && $stable(enS_reg);
  endproperty
  a_ns_write: assert property (p_ns_write)
    else $error("non-secure write wrong");

  property p_alias;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && regRdStb && isCtrl && secView)
      |=> regRdData == {30'h0, $past(enNs_reg), $past(enS_reg)};
  endproperty
  a_alias: assert property (p_alias)
    else $error("secure view wrong");

  property p_rsvd;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && regRdStb && isCtrl) |=> regRdData[31:2] == 30'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved control bits set");

  property p_id_nowrite;
    @(posedge mclk) disable iff (sys_rst)
      (regWrStb && isId) |=> $stable(enNs_reg) && $stable(enS_reg);
  endproperty
  a_id_nowrite: assert property (p_id_nowrite)
    else $error("id write changed state");

  property p_id_hi;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && regRdStb && isId) |=> regRdData[31:8] == 24'h0;
  endproperty
  a_id_hi: assert property (p_id_hi)
    else $error("id upper bits set");

  property p_sec_gate;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && SEC_EXT && !enS_reg) |=> !secIrqOut;
  endproperty
  a_sec_gate: assert property (p_sec_gate)
    else $error("secure irq while disabled");

  property p_ns_pass;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && enNs_reg && nsIrqPend) |=> nsIrqOut;
  endproperty
  a_ns_pass: assert property (p_ns_pass)
    else $error("enabled non-secure irq not signalled");

  // alias bit sits in the secure copy, so lockdown guards it from secure writes; non-secure writes still land
  property p_lock_alias;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && secLocked && regWrStb && isCtrl && secView)
      |=> $stable(enNs_reg);
  endproperty
  a_lock_alias: assert property (p_lock_alias)
    else $error("alias changed under lockdown");

  property p_unmapped;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && regRdStb && !isCtrl && !isId)
      |=> regRdData == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_rd_idle;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && !regRdStb) |=> regRdData == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");
endmodule // cicid_ctrl

// ===== common/cicid_map.svh
// Purpose: offsets, field positions and reset values of the cpu interface
//          control and identification registers
// Assumes: word-aligned byte offsets on the register port
// Notes:   definitions only
`ifndef CICID_MAP_SVH
`define CICID_MAP_SVH

// ============================================================
// offsets
`define CICID_OFF_CTRL      12'h000
`define CICID_OFF_PID4      12'hFD0
`define CICID_OFF_PID5      12'hFD4
`define CICID_OFF_PID6      12'hFD8
`define CICID_OFF_PID7      12'hFDC
`define CICID_OFF_PID0      12'hFE0
`define CICID_OFF_PID1      12'hFE4
`define CICID_OFF_PID2      12'hFE8
`define CICID_OFF_PID3      12'hFEC

// ============================================================
// control fields
`define CICID_CTRL_EN_BIT   0
`define CICID_CTRL_ENNS_BIT 1
`define CICID_CTRL_RESET    1'b0

// ============================================================
// identifier fields
`define CICID_ID_RSVD_HI    63
`define CICID_ID_RSVD_LO    36
`define CICID_ID_BANK_LO    32
`define CICID_ID_REV_LO     28
`define CICID_ID_ARCH_REV_LO 20
`define CICID_ID_JEP_BIT    19
`define CICID_ID_ARCH_LO    12
`define CICID_ID_DEV_LO     0
`define CICID_PID2_JEP_BIT  3
`define CICID_JEP_FLAG      1'b1
// arbitrary neutral values, not a real maker or part
`define CICID_BANK_CODE     4'h7
`define CICID_REVISION      4'h2
`define CICID_ARCH_REV      4'h2
`define CICID_ARCH_CODE     7'h55
`define CICID_DEVICE_CODE   12'h123

`endif

// ===== common/cicid_pkg.sv
// Purpose: shared types of the control and identification block
// Assumes: nothing
// Notes:   offsets live in cicid_map.svh
package cicid_pkg;
  typedef logic [31:0] cicid_word_t;
  typedef logic [63:0] cicid_id_t;
  typedef enum logic [1:0] {
    CICID_SEL_NONE,
    CICID_SEL_CTRL,
    CICID_SEL_ID
  } cicid_sel_t;
endpackage

// ===== design/cicid_sync2.sv
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: mclk domain, synchronous reset
// Notes:   first stage read only by the second
module cicid_sync2
  import cicid_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sysRst,
  input  wire logic clkEn,
  input  wire logic pinIn,
  output logic      levelOut
);
  logic stage1_reg;
  logic stage1_next;
  logic stage2_reg;
  logic stage2_next;

  always_comb
  begin
    stage1_next = stage1_reg;
    stage2_next = stage2_reg;
    if (clkEn)
    begin
      stage1_next = pinIn;
      stage2_next = stage1_reg;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sysRst)
    begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end
    else
    begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign levelOut = stage2_reg;
endmodule // cicid_sync2

// ===== design/cicid_id_rom.sv
// Purpose: peripheral identifier bytes, selected by offset
// Assumes: byte index 0..7 decoded by the caller
// Notes:   constant contents, read data registered
`include "cicid_map.svh"
module cicid_id_rom
  import cicid_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sysRst,
  input  wire logic       clkEn,
  input  wire logic       rdEn,
  input  wire logic [2:0] byteSel,
  output logic [7:0]      rdByte
);
  cicid_id_t  idWord;
  logic [7:0] rdByte_reg;
  logic [7:0] rdByte_next;

  // ============================================================
  // identifier assembly
  always_comb
  begin
    idWord = '0; // upper bits stay zero
    idWord[`CICID_ID_BANK_LO +: 4]    = `CICID_BANK_CODE;
    idWord[`CICID_ID_REV_LO +: 4]     = `CICID_REVISION;
    idWord[`CICID_ID_ARCH_REV_LO +: 4] = `CICID_ARCH_REV;
    idWord[`CICID_ID_JEP_BIT]         = `CICID_JEP_FLAG;
    idWord[`CICID_ID_ARCH_LO +: 7]    = `CICID_ARCH_CODE;
    idWord[`CICID_ID_DEV_LO +: 12]    = `CICID_DEVICE_CODE;
  end

  always_comb
  begin
    rdByte_next = rdByte_reg;
    if (clkEn && rdEn)
      rdByte_next = idWord[{byteSel, 3'b000} +: 8];
  end

  always_ff @(posedge mclk)
  begin
    if (sysRst)
      rdByte_reg <= 8'h00;
    else
      rdByte_reg <= rdByte_next;
  end

  assign rdByte = rdByte_reg;

  // ============================================================
  // checks
  property p_jep_bit;
    @(posedge mclk) disable iff (sysRst)
      (clkEn && rdEn && byteSel == 3'h2)
      |=> rdByte[`CICID_PID2_JEP_BIT] == 1'b1;
  endproperty
  a_jep_bit: assert property (p_jep_bit)
    else $error("jedec flag not one");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (sysRst)
      (clkEn && rdEn && byteSel > 3'h4) |=> rdByte == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved id byte not zero");

  property p_pid4_hi;
    @(posedge mclk) disable iff (sysRst)
      (clkEn && rdEn && byteSel == 3'h4)
      |=> rdByte == {4'h0, `CICID_BANK_CODE};
  endproperty
  a_pid4_hi: assert property (p_pid4_hi)
    else $error("bank code byte wrong");
endmodule // cicid_id_rom

// ===== tb/cicid_core_model.sv
// Purpose: processor core that takes the two request levels
// Assumes: same clock as the controller
// Notes:   registers what it sees, one cycle later
module cicid_core_model
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic secIrq,
  input  wire logic nsIrq,
  output logic      secTaken,
  output logic      nsTaken
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // request capture
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      secTaken <= 1'b0;
      nsTaken  <= 1'b0;
    end
    else
    begin
      secTaken <= secIrq;
      nsTaken  <= nsIrq;
    end
  end
endmodule // cicid_core_model

// ===== tb/tb_cicid_ctrl.sv
// Purpose: self-checking bench of the control and id block
// Assumes: security extensions and lockdown both present
// Notes:   reads are scored by a negedge monitor from a queue
`include "cicid_map.svh"
module tb_cicid_ctrl;
  import cicid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clkEn = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0;
  logic        regWrStb = 1'b0;
  logic        regRdStb = 1'b0;
  logic        accSecure = 1'b0;
  logic        lockdownPin = 1'b0;
  logic        secIrqPend = 1'b0;
  logic        nsIrqPend = 1'b0;
  logic [31:0] regRdData;
  logic        secIrqOut;
  logic        nsIrqOut;
  logic        secTaken;
  logic        nsTaken;
  logic        rdSeen = 1'b0;
  logic        enS = 1'b0;
  logic        enNs = 1'b0;
  logic [31:0] rnd = 32'h11967F6B;
  logic [31:0] expQ[$];
  int          errCount = 0;
  int          numChecks = 0;
  localparam cicid_id_t ID_EXP = {28'h0, `CICID_BANK_CODE, `CICID_REVISION,
    4'h0, `CICID_ARCH_REV, `CICID_JEP_FLAG, `CICID_ARCH_CODE,
    `CICID_DEVICE_CODE};
  logic [11:0] idOff[8] = '{`CICID_OFF_PID0, `CICID_OFF_PID1,
    `CICID_OFF_PID2, `CICID_OFF_PID3, `CICID_OFF_PID4, `CICID_OFF_PID5,
    `CICID_OFF_PID6, `CICID_OFF_PID7};
  always #2.5 mclk = ~mclk;
  cicid_ctrl #(.SEC_EXT(1'b1), .LOCKDOWN(1'b1)) DUT (.mclk(mclk),
    .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .accSecure(accSecure), .lockdownPin(lockdownPin),
    .secIrqPend(secIrqPend), .nsIrqPend(nsIrqPend), .regRdData(regRdData),
    .secIrqOut(secIrqOut), .nsIrqOut(nsIrqOut));
  cicid_core_model core (.mclk(mclk), .sys_rst(sys_rst), .secIrq(secIrqOut),
    .nsIrq(nsIrqOut), .secTaken(secTaken), .nsTaken(nsTaken));
  // ========================================
  // helpers
  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic s);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= d;
    accSecure <= s;
    regWrStb  <= 1'b1;
    @(posedge mclk);
    regWrStb  <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic s,
                    input logic [31:0] exp);
    @(posedge mclk);
    regAddr   <= a;
    accSecure <= s;
    regRdStb  <= 1'b1;
    expQ.push_back(exp);
    @(posedge mclk);
    regRdStb  <= 1'b0;
  endtask
  // random pending levels, outputs judged at the core one edge later
  task automatic irqChk();
    logic sp;
    logic np;
    rnd = lfsrNext(rnd);
    sp = rnd[0];
    np = rnd[1];
    @(posedge mclk);
    secIrqPend <= sp;
    nsIrqPend  <= np;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("secure request", {31'h0, secTaken}, {31'h0, sp & enS});
    check("ns request", {31'h0, nsTaken}, {31'h0, np & enNs});
  endtask
  task automatic ctrlChk();
    rd(`CICID_OFF_CTRL, 1'b0, {31'h0, enNs});
    rd(`CICID_OFF_CTRL, 1'b1, {30'h0, enNs, enS});
    repeat (4) irqChk();
  endtask
  // ========================================
  // read monitor: data stands only in the cycle after the strobe
  always @(negedge mclk)
  begin
    if (rdSeen)
    begin
      if (expQ.size() == 0)
        check("unexpected read", 32'h1, 32'h0);
      else
        check("read data", regRdData, expQ.pop_front());
    end
    rdSeen = regRdStb;
  end
  initial
  begin
    repeat (5000) @(posedge mclk);
    errCount++;
    conclude();
  end
  // ========================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    // identifier bytes, then writes to them change nothing
    for (int k = 0; k < 8; k++)
      rd(idOff[k], 1'b0, {24'h0, ID_EXP[8*k +: 8]});
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsrNext(rnd);
      wr(idOff[k], rnd, k[0]);
      rd(idOff[k], 1'b1, {24'h0, ID_EXP[8*k +: 8]});
    end
    rd(12'h004, 1'b1, 32'h0);
    $display("test id done");
    ctrlChk();
    rnd = lfsrNext(rnd);
    wr(`CICID_OFF_CTRL, rnd | 32'h1, 1'b0);
    enNs = 1'b1;
    ctrlChk();
    wr(`CICID_OFF_CTRL, 32'hFFFFFFFD, 1'b1);
    enS  = 1'b1;
    enNs = 1'b0;
    ctrlChk();
    wr(`CICID_OFF_CTRL, 32'hFFFFFFFE, 1'b0);
    ctrlChk();
    $display("test banking done");
    // lockdown: pin is synchronised, so allow a few edges
    @(posedge mclk);
    lockdownPin <= 1'b1;
    repeat (5) @(posedge mclk);
    wr(`CICID_OFF_CTRL, 32'h2, 1'b1);
    ctrlChk();
    wr(`CICID_OFF_CTRL, 32'h1, 1'b0);
    enNs = 1'b1;
    ctrlChk();
    @(posedge mclk);
    lockdownPin <= 1'b0;
    repeat (5) @(posedge mclk);
    wr(`CICID_OFF_CTRL, 32'h0, 1'b1);
    enS  = 1'b0;
    enNs = 1'b0;
    ctrlChk();
    $display("test lockdown done");
    // frozen clock enable: a write must not land
    @(posedge mclk);
    clkEn <= 1'b0;
    wr(`CICID_OFF_CTRL, 32'h3, 1'b1);
    clkEn <= 1'b1;
    ctrlChk();
    $display("test freeze done");
    for (int i = 0; i < 10 && expQ.size() > 0; i++)
      @(posedge mclk);
    if (expQ.size() > 0)
      errCount++;
    conclude();
  end
endmodule // tb_cicid_ctrl
